// ===== spb_params.svh
// constants of the serial port buffer block
`ifndef SPB_PARAMS_SVH
`define SPB_PARAMS_SVH
// register indices on the plain register port
`define SPB_REG_STAT    3'h0
`define SPB_REG_CON1    3'h1
`define SPB_REG_CON2    3'h2
`define SPB_REG_DATA    3'h3
`define SPB_REG_INTST   3'h4
`define SPB_REG_INTMSK  3'h5
// status register fields
`define SPB_STAT_EN     15
`define SPB_STAT_BUSY   7
`define SPB_STAT_TBF    1
`define SPB_STAT_RBF    0
// control one fields
`define SPB_CON1_MASK   16'h1fff
`define SPB_CON1_RST    16'h0000
`define SPB_CON1_DSCK   12
`define SPB_CON1_DSDO   11
`define SPB_CON1_W16    10
`define SPB_CON1_SMP    9
`define SPB_CON1_CKE    8
`define SPB_CON1_CKP    6
`define SPB_CON1_MST    5
// control two fields
`define SPB_CON2_FIFO   0
// interrupt status bits
`define SPB_INT_RXDONE  0
`define SPB_INT_TXLOAD  1
`define SPB_INT_OVF     2
`define SPB_INT_W       3
// buffer depth and limits
`define SPB_DEPTH       8
`define SPB_LIM_FIFO    4'h8
`define SPB_LIM_STD     4'h1
// word widths in bits
`define SPB_BITS16      5'h10
`define SPB_BITS8       5'h08
// master serial clock half period
`define SPB_CLK_NS      5
`define SPB_HALF_NS     40
`define SPB_HALF_CYC    (`SPB_HALF_NS / `SPB_CLK_NS)
`endif

// ===== spb_pkg.sv
// types of the serial port buffer block
package spb_pkg;
    // master engine states
    typedef enum logic [0:0] {
        st_idle,
        st_run
    } spb_state_e;
endpackage : spb_pkg

// ===== spb_sync.sv
// two flip-flop synchroniser for the serial pins
`timescale 1ns/10ps
`default_nettype none
module spb_sync (
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic [2:0] async_in,
    output var  logic [2:0] sync_out
);
    logic [2:0] meta;         // first stage, read only by second
    logic [2:0] next_meta;    // next first stage
    logic [2:0] next_sync;    // next second stage

    // next values of both stages
    always_comb begin
        next_meta = async_in;
        next_sync = meta;
    end

    // register both stages
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            meta     <= 3'h0;
            sync_out <= 3'h0;
        end else begin
            meta     <= next_meta;
            sync_out <= next_sync;
        end
    end
endmodule : spb_sync
`default_nettype wire

// ===== spb_fifo.sv
// word buffer with a run-time depth limit
`timescale 1ns/10ps
`default_nettype none
`include "spb_params.svh"
module spb_fifo (
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic        push_in,
    input  wire logic        pop_in,
    input  wire logic [15:0] data_in,
    input  wire logic [3:0]  limit_in,
    output var  logic [15:0] data_out,
    output var  logic        full_out,
    output var  logic        empty_out,
    output var  logic [3:0]  count_out
);
    logic [15:0] mem [0:`SPB_DEPTH-1];      // entries
    logic [15:0] next_mem [0:`SPB_DEPTH-1]; // next entries
    logic [2:0]  wptr, next_wptr;           // write index
    logic [2:0]  rptr, next_rptr;           // read index
    logic [3:0]  next_count;                // next fill level
    logic        push_ok;                   // push accepted
    logic        pop_ok;                    // pop accepted

    // flags and head word
    always_comb begin
        full_out  = (count_out >= limit_in);
        empty_out = (count_out == 4'h0);
        data_out  = mem[rptr];
        push_ok   = push_in && !full_out;
        pop_ok    = pop_in && !empty_out;
        next_mem  = mem;
        next_wptr = wptr;
        next_rptr = rptr;
        next_count = count_out;
        // a push into a full buffer is dropped
        if (push_ok) begin
            next_mem[wptr] = data_in;
            next_wptr      = wptr + 3'h1;
        end
        // a pop of an empty buffer is ignored
        if (pop_ok) begin
            next_rptr = rptr + 3'h1;
        end
        next_count = count_out + {3'h0, push_ok} - {3'h0, pop_ok};
    end

    // pointers and level
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            wptr      <= 3'h0;
            rptr      <= 3'h0;
            count_out <= 4'h0;
        end else begin
            wptr      <= next_wptr;
            rptr      <= next_rptr;
            count_out <= next_count;
        end
    end

    // storage, one flop row per entry
    genvar gi;
    generate
        for (gi = 0; gi < `SPB_DEPTH; gi = gi + 1) begin : g_ent
            always_ff @(posedge mclk_in) begin
                mem[gi] <= next_mem[gi];
            end
        end
    endgenerate
endmodule : spb_fifo
`default_nettype wire

// ===== spb_core.sv
// serial port buffer flags, control and shift engine
//
// Contract
// - standard mode: write sets transmit full
// - standard mode: load to shifter clears it
// - fifo mode: write filling last entry sets
// - fifo mode: free entry clears transmit full
// - standard mode: received word sets receive full
// - standard mode: data read clears receive full
// - fifo mode: word filling last entry sets
// - fifo mode: free entry clears receive full
// - master samples end or middle by phase
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "spb_params.svh"
module spb_core (
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic [2:0]  addr_in,
    input  wire logic [15:0] wr_data_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output var  logic [15:0] rd_data_out,
    output var  logic        irq_out,
    input  wire logic        sck_in,
    output var  logic        sck_out,
    output var  logic        sck_oe_n_out,
    input  wire logic        sdi_in,
    output var  logic        sdo_out,
    output var  logic        sdo_oe_n_out,
    input  wire logic        ss_n_in
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic                       en;          // port enable
    logic [15:0]                con1;        // control one
    logic                       fifo_mode;   // eight level mode
    logic [`SPB_INT_W-1:0]      int_st;      // sticky events
    logic [`SPB_INT_W-1:0]      int_msk;     // event mask
    spb_pkg::spb_state_e        state;       // master engine state
    logic [3:0]                 half_cnt;    // half period counter
    logic                       half_ph;     // second half of bit
    logic [4:0]                 bit_cnt;     // bits done in word
    logic [15:0]                tx_sr;       // outgoing shift reg
    logic [15:0]                rx_sr;       // incoming shift reg
    logic                       sl_loaded;   // slave word loaded
    logic                       sck_prev;    // last synced clock
    // next values
    logic                       next_en;
    logic [15:0]                next_con1;
    logic                       next_fifo_mode;
    logic [`SPB_INT_W-1:0]      next_int_st;
    logic [`SPB_INT_W-1:0]      next_int_msk;
    spb_pkg::spb_state_e        next_state;
    logic [3:0]                 next_half_cnt;
    logic                       next_half_ph;
    logic [4:0]                 next_bit_cnt;
    logic [15:0]                next_tx_sr;
    logic [15:0]                next_rx_sr;
    logic                       next_sl_loaded;
    logic [15:0]                next_rd_data;
    logic                       next_irq;
    logic                       next_sck;
    logic                       next_sck_oe_n;
    logic                       next_sdo;
    logic                       next_sdo_oe_n;
    // ------------------------------------------------------------
    // wiring
    // ------------------------------------------------------------
    logic [2:0]  pins_s;      // synced {ss_n, sdi, sck}
    logic        sck_s;       // synced clock pin
    logic        sdi_s;       // synced data in
    logic        ss_n_s;      // synced select
    logic        mst;         // master mode
    logic        sample_phase_sel;         // sample phase select
    logic        cke;         // clock edge select
    logic        ckp;         // idle clock level
    logic [4:0]  width;       // bits per word
    logic [3:0]  limit;       // buffer depth in use
    logic        tx_push;     // cpu data write
    logic        rx_pop;      // cpu data read
    logic        tx_pop;      // word to shifter
    logic        rx_push;     // word from shifter
    logic [15:0] rx_word;     // word to receive buffer
    logic [15:0] tx_head;     // next word to send
    logic [15:0] rx_head;     // oldest unread word
    logic        tx_full;     // tx_full_flag
    logic        rx_full;     // rx_full_flag
    logic        tx_empty;    // nothing to send
    logic        rx_empty;    // nothing to read
    logic [3:0]  tx_count;    // transmit level
    logic [3:0]  rx_count;    // receive level
    logic        ev_ovf;      // word lost, buffer full
    logic        tick;        // half period elapsed
    logic        rise;        // synced clock rose
    logic        fall;        // synced clock fell
    logic        smp_edge;    // slave sample edge
    logic        chg_edge;    // slave change edge
    logic [15:0] ld;          // aligned load word
    logic [15:0] rx_nx;       // shifter after a sample

    assign sck_s  = pins_s[0];
    assign sdi_s  = pins_s[1];
    assign ss_n_s = pins_s[2];
    assign mst    = con1[`SPB_CON1_MST];
    assign sample_phase_sel    = con1[`SPB_CON1_SMP];
    assign cke    = con1[`SPB_CON1_CKE];
    assign ckp    = con1[`SPB_CON1_CKP];

    // pins into the clock domain
    spb_sync u_sync (
        .mclk_in  (mclk_in),
        .rst_in   (rst_in),
        .async_in ({ss_n_in, sdi_in, sck_in}),
        .sync_out (pins_s)
    );

    // transmit buffer, depth one in standard mode
    spb_fifo u_txf (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .push_in   (tx_push),
        .pop_in    (tx_pop),
        .data_in   (wr_data_in),
        .limit_in  (limit),
        .data_out  (tx_head),
        .full_out  (tx_full),
        .empty_out (tx_empty),
        .count_out (tx_count)
    );

    // receive buffer, depth one in standard mode
    spb_fifo u_rxf (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .push_in   (rx_push),
        .pop_in    (rx_pop),
        .data_in   (rx_word),
        .limit_in  (limit),
        .data_out  (rx_head),
        .full_out  (rx_full),
        .empty_out (rx_empty),
        .count_out (rx_count)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        rx_nx = rx_sr;
        // full flags follow buffer level against limit
        limit = fifo_mode ? `SPB_LIM_FIFO : `SPB_LIM_STD;
        width = con1[`SPB_CON1_W16] ? `SPB_BITS16 : `SPB_BITS8;
        ld    = con1[`SPB_CON1_W16] ? tx_head : {tx_head[7:0], 8'h00};
        tx_push = wr_in && (addr_in == `SPB_REG_DATA);
        rx_pop  = rd_in && (addr_in == `SPB_REG_DATA);
        tick  = (half_cnt == 4'(`SPB_HALF_CYC - 1));
        rise  = sck_s && !sck_prev;
        fall  = !sck_s && sck_prev;
        smp_edge = (cke ^ ckp) ? rise : fall;
        chg_edge = (cke ^ ckp) ? fall : rise;
        tx_pop  = 1'b0;
        rx_push = 1'b0;
        next_en        = en;
        next_con1      = con1;
        next_fifo_mode = fifo_mode;
        next_int_msk   = int_msk;
        next_state     = state;
        next_half_cnt  = half_cnt;
        next_half_ph   = half_ph;
        next_bit_cnt   = bit_cnt;
        next_tx_sr     = tx_sr;
        next_rx_sr     = rx_sr;
        next_sl_loaded = sl_loaded;
        next_sdo       = sdo_out;
        next_sck       = ckp;
        // register writes
        if (wr_in) begin
            case (addr_in)
                `SPB_REG_STAT:   next_en = wr_data_in[`SPB_STAT_EN];
                `SPB_REG_CON1:   next_con1 = wr_data_in & `SPB_CON1_MASK;
                `SPB_REG_CON2:   next_fifo_mode = wr_data_in[`SPB_CON2_FIFO];
                `SPB_REG_INTMSK: next_int_msk = wr_data_in[`SPB_INT_W-1:0];
                default:         next_en = en;
            endcase
        end
        // master engine
        if (!en || !mst) begin
            next_state = spb_pkg::st_idle;
        end else begin
            case (state)
                spb_pkg::st_idle: begin
                    // load holding word into shifter, frees entry
                    if (!tx_empty) begin
                        tx_pop        = 1'b1;
                        next_sdo      = ld[15];
                        next_tx_sr    = {ld[14:0], 1'b0};
                        next_half_cnt = 4'h0;
                        next_half_ph  = 1'b0;
                        next_bit_cnt  = 5'h00;
                        next_state    = spb_pkg::st_run;
                    end
                end
                spb_pkg::st_run: begin
                    next_half_cnt = half_cnt + 4'h1;
                    if (tick) begin
                        next_half_cnt = 4'h0;
                        next_half_ph  = !half_ph;
                        // sample mid bit or end of bit
                        if (half_ph == sample_phase_sel) begin
                            rx_nx      = {rx_sr[14:0], sdi_s};
                            next_rx_sr = rx_nx;
                        end
                        if (half_ph) begin
                            next_bit_cnt = bit_cnt + 5'h01;
                            if (next_bit_cnt == width) begin
                                rx_push    = 1'b1;
                                next_state = spb_pkg::st_idle;
                            end else begin
                                next_sdo   = tx_sr[15];
                                next_tx_sr = {tx_sr[14:0], 1'b0};
                            end
                        end
                    end
                    next_sck = ckp ^ (cke ? next_half_ph : !next_half_ph);
                end
                default: next_state = spb_pkg::st_idle;
            endcase
        end
        // slave engine, clocked by the synced pin
        if (en && !mst) begin
            if (!sl_loaded && !tx_empty) begin
                tx_pop         = 1'b1;
                next_sl_loaded = 1'b1;
                next_tx_sr     = cke ? {ld[14:0], 1'b0} : ld;
                next_sdo       = cke ? ld[15] : sdo_out;
            end
            if (ss_n_s) begin
                next_bit_cnt = 5'h00;
            end else if (smp_edge) begin
                rx_nx        = {rx_sr[14:0], sdi_s};
                next_rx_sr   = rx_nx;
                next_bit_cnt = bit_cnt + 5'h01;
                if (next_bit_cnt == width) begin
                    rx_push        = 1'b1;
                    next_bit_cnt   = 5'h00;
                    next_sl_loaded = 1'b0;
                end
            end else if (chg_edge) begin
                next_sdo   = tx_sr[15];
                next_tx_sr = {tx_sr[14:0], 1'b0};
            end
        end
        rx_word = con1[`SPB_CON1_W16] ? rx_nx : {8'h00, rx_nx[7:0]};
        // a word into a full receive buffer is discarded
        ev_ovf = rx_push && rx_full && !rx_pop;
        // events set, reading interrupt status clears; set wins
        next_int_st = int_st;
        if (rd_in && (addr_in == `SPB_REG_INTST)) begin
            next_int_st = '0;
        end
        next_int_st[`SPB_INT_RXDONE] = next_int_st[`SPB_INT_RXDONE] | rx_push;
        next_int_st[`SPB_INT_TXLOAD] = next_int_st[`SPB_INT_TXLOAD] | tx_pop;
        next_int_st[`SPB_INT_OVF]    = next_int_st[`SPB_INT_OVF] | ev_ovf;
        next_irq = |(next_int_st & next_int_msk);
        // pin drive, low enable means driving
        next_sck_oe_n = !(next_en && next_con1[`SPB_CON1_MST]
                          && !next_con1[`SPB_CON1_DSCK]);
        next_sdo_oe_n = !(next_en && !next_con1[`SPB_CON1_DSDO]
                          && (next_con1[`SPB_CON1_MST] || !ss_n_s));
        // register read mux
        next_rd_data = 16'h0000;
        if (rd_in) begin
            case (addr_in)
                `SPB_REG_STAT: begin
                    next_rd_data[`SPB_STAT_EN]   = en;
                    next_rd_data[`SPB_STAT_BUSY] = (state == spb_pkg::st_run);
                    next_rd_data[`SPB_STAT_TBF]  = tx_full;
                    next_rd_data[`SPB_STAT_RBF]  = rx_full;
                end
                `SPB_REG_CON1:   next_rd_data = con1;
                `SPB_REG_CON2:   next_rd_data[`SPB_CON2_FIFO] = fifo_mode;
                `SPB_REG_DATA:   next_rd_data = rx_empty ? 16'h0000 : rx_head;
                `SPB_REG_INTST:  next_rd_data[`SPB_INT_W-1:0] = int_st;
                `SPB_REG_INTMSK: next_rd_data[`SPB_INT_W-1:0] = int_msk;
                default:         next_rd_data = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            en           <= 1'b0;
            con1         <= `SPB_CON1_RST;
            fifo_mode    <= 1'b0;
            int_st       <= '0;
            int_msk      <= '0;
            state        <= spb_pkg::st_idle;
            half_cnt     <= 4'h0;
            half_ph      <= 1'b0;
            bit_cnt      <= 5'h00;
            tx_sr        <= 16'h0000;
            rx_sr        <= 16'h0000;
            sl_loaded    <= 1'b0;
            sck_prev     <= 1'b0;
            rd_data_out  <= 16'h0000;
            irq_out      <= 1'b0;
            sck_out      <= 1'b0;
            sck_oe_n_out <= 1'b1;
            sdo_out      <= 1'b0;
            sdo_oe_n_out <= 1'b1;
        end else begin
            en           <= next_en;
            con1         <= next_con1;
            fifo_mode    <= next_fifo_mode;
            int_st       <= next_int_st;
            int_msk      <= next_int_msk;
            state        <= next_state;
            half_cnt     <= next_half_cnt;
            half_ph      <= next_half_ph;
            bit_cnt      <= next_bit_cnt;
            tx_sr        <= next_tx_sr;
            rx_sr        <= next_rx_sr;
            sl_loaded    <= next_sl_loaded;
            sck_prev     <= sck_s;
            rd_data_out  <= next_rd_data;
            irq_out      <= next_irq;
            sck_out      <= next_sck;
            sck_oe_n_out <= next_sck_oe_n;
            sdo_out      <= next_sdo;
            sdo_oe_n_out <= next_sdo_oe_n;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    a_tx_std_set: assert property (
        !fifo_mode && tx_push && tx_empty |=> tx_full
    ) else $error("transmit full not set by write");
    a_tx_std_clr: assert property (
        !fifo_mode && tx_pop && !tx_push |=> !tx_full
    ) else $error("transmit full not cleared on load");
    a_tx_fifo_set: assert property (
        fifo_mode && tx_push && tx_count == 4'h7 && !tx_pop |=> tx_full
    ) else $error("transmit full not set on last entry");
    a_tx_fifo_clr: assert property (
        fifo_mode && tx_full && tx_pop && !tx_push |=> !tx_full ##1 1'b1
    ) else $error("transmit full not cleared on free entry");
    a_rx_std_set: assert property (
        !fifo_mode && rx_push && rx_empty |=> rx_full
    ) else $error("receive full not set by word");
    a_rx_std_clr: assert property (
        !fifo_mode && rx_pop && rx_full && !rx_push |=> !rx_full
    ) else $error("receive full not cleared by read");
    a_rx_fifo_set: assert property (
        fifo_mode && rx_push && rx_count == 4'h7 && !rx_pop |=> rx_full
    ) else $error("receive full not set on last entry");
    a_rx_fifo_clr: assert property (
        fifo_mode && rx_full && rx_pop && !rx_push |=> !rx_full
    ) else $error("receive full not cleared on free entry");
    a_master_sample: assert property (
        state == spb_pkg::st_run && en && mst && tick && half_ph == sample_phase_sel
        |=> rx_sr[0] == $past(sdi_s)
    ) else $error("master missed its sample point");
    a_master_hold: assert property (
        state == spb_pkg::st_run && en && mst && tick && half_ph != sample_phase_sel
        |=> rx_sr == $past(rx_sr)
    ) else $error("master sampled in wrong half");
    a_word_width: assert property (
        state == spb_pkg::st_run && mst |-> bit_cnt < width
    ) else $error("bit count past word width");
    a_clk_release: assert property (
        con1[`SPB_CON1_DSCK] |-> sck_oe_n_out
    ) else $error("clock pin driven while disabled");
endmodule : spb_core
`default_nettype wire

// ===== spb_peer.sv
// serial peripheral model standing on the far side of the master port
`timescale 1ns/10ps
`default_nettype none
module spb_peer (
    input  wire logic        sck_in,
    input  wire logic        sdo_in,
    input  wire logic        wide_in,
    output var  logic        sdi_out,
    output var  logic [15:0] got_out
);
    // ----------------------------------------
    // daisy-chain shifter: replies with the previous word
    // ----------------------------------------
    logic [15:0] sh  = 16'h5aa5; // first reply, arbitrary pattern
    logic        cap = 1'b0;     // bit taken on the active edge
    logic        lvl = 1'b0;     // last settled clock level, idle low
    // take the master's bit in mid-bit on a true rise, move on at the bit
    // boundary on a true fall; the unknown level before reset is no edge
    always @(sck_in) begin
        if (sck_in === 1'b1 && lvl === 1'b0) cap <= sdo_in;
        if (sck_in === 1'b0 && lvl === 1'b1) sh <= {sh[14:0], cap};
        if (sck_in === 1'b0 || sck_in === 1'b1) lvl = sck_in;
    end
    assign sdi_out = wide_in ? sh[15] : sh[7];
    assign got_out = sh;
endmodule : spb_peer
`default_nettype wire

// ===== spb_core_bench.sv
// self-checking bench for the serial port buffer block
`timescale 1ns/10ps
`default_nettype none
`include "spb_params.svh"
module spb_core_bench;
    logic        mclk_in = 1'b0;
    logic        rst_in  = 1'b1;
    logic [2:0]  addr    = 3'h0;
    logic [15:0] wdat    = 16'h0000;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic        wide    = 1'b0;
    logic [15:0] rdat, got;
    logic        irq, sck_o, sck_oe_n, sdo, sdo_oe_n, sdi, sck;
    int          failures  = 0;
    int          tests_run = 0;
    // pins pulled low while the block does not drive them
    assign sck = sck_oe_n ? 1'b0 : sck_o;
    always #2.5 mclk_in = ~mclk_in;
    spb_core dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr), .wr_data_in(wdat),
        .wr_in(wr), .rd_in(rd), .rd_data_out(rdat), .irq_out(irq), .sck_in(sck),
        .sck_out(sck_o), .sck_oe_n_out(sck_oe_n), .sdi_in(sdi), .sdo_out(sdo),
        .sdo_oe_n_out(sdo_oe_n), .ss_n_in(1'b1));
    spb_peer peer_u (.sck_in(sck), .sdo_in(sdo_oe_n ? 1'b0 : sdo), .wide_in(wide),
        .sdi_out(sdi), .got_out(got));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic wreg(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        addr <= a;
        wdat <= d;
        wr   <= 1'b1;
        @(posedge mclk_in);
        wr   <= 1'b0;
    endtask : wreg
    // read data stand only in the cycle after the strobe
    task automatic rreg(input logic [2:0] a, output logic [15:0] d);
        @(posedge mclk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk_in);
        rd   <= 1'b0;
        #1 d = rdat;
    endtask : rreg
    // poll a status flag under a bounded count
    task automatic wait_flag(input int b, input logic v);
        logic [15:0] s;
        for (int n = 0; n < 3000; n++) begin
            rreg(`SPB_REG_STAT, s);
            if (s[b] === v) return;
        end
        failures++;
        $display("wrong value at %0t: status flag stuck", $time);
        conclude();
    endtask : wait_flag
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset();
        logic [15:0] v;
        rreg(`SPB_REG_STAT, v);
        check(v, 16'h0000);
        rreg(`SPB_REG_CON1, v);
        check(v, 16'h0000);
        rreg(3'h7, v);
        check(v, 16'h0000);
        check({11'h0, irq, sck_oe_n, sdo_oe_n, sck_o, sdo}, 16'h000c);
    endtask : test_reset
    // single buffer, 8-bit words, mid-bit sampling, interrupt raised and cleared
    task automatic test_standard();
        logic [15:0] v;
        wreg(`SPB_REG_CON1, 16'h0120);
        wreg(`SPB_REG_INTMSK, 16'h0001);
        wreg(`SPB_REG_DATA, 16'h00c3);
        rreg(`SPB_REG_STAT, v);
        check(v, 16'h0002);
        wreg(`SPB_REG_DATA, 16'h0011);
        wreg(`SPB_REG_STAT, 16'h8000);
        wait_flag(`SPB_STAT_TBF, 1'b0);
        wait_flag(`SPB_STAT_RBF, 1'b1);
        check({15'h0, irq}, 16'h0001);
        rreg(`SPB_REG_DATA, v);
        check(v, 16'h00a5);
        check(got, 16'ha5c3);
        rreg(`SPB_REG_STAT, v);
        check(v & 16'h0003, 16'h0000);
        rreg(`SPB_REG_INTST, v);
        check(v, 16'h0003);
        rreg(`SPB_REG_INTST, v);
        check({irq, v[14:0]}, 16'h0000);
    endtask : test_standard
    // eight-level buffers, 16-bit words, end-of-bit sampling, interrupt masked
    task automatic test_fifo();
        logic [15:0] v;
        wreg(`SPB_REG_STAT, 16'h0000);
        wreg(`SPB_REG_INTMSK, 16'h0000);
        wreg(`SPB_REG_CON1, 16'h0720);
        wreg(`SPB_REG_CON2, 16'h0001);
        wide = 1'b1;
        for (int i = 0; i < 8; i++) begin
            wreg(`SPB_REG_DATA, 16'h1000 + 16'(i));
            rreg(`SPB_REG_STAT, v);
            check({15'h0, v[1]}, {15'h0, i == 7});
        end
        wreg(`SPB_REG_STAT, 16'h8000);
        wait_flag(`SPB_STAT_TBF, 1'b0);
        wait_flag(`SPB_STAT_RBF, 1'b1);
        check({15'h0, irq}, 16'h0000);
        rreg(`SPB_REG_DATA, v);
        check(v, 16'ha5c3);
        rreg(`SPB_REG_STAT, v);
        check({15'h0, v[0]}, 16'h0000);
        for (int i = 1; i < 8; i++) begin
            rreg(`SPB_REG_DATA, v);
            check(v, 16'h0fff + 16'(i));
        end
        check(got, 16'h1007);
    endtask : test_fifo
    // disable bits release the clock and data pins of an enabled master
    task automatic test_release();
        logic [15:0] v;
        wreg(`SPB_REG_CON1, 16'h1820);
        rreg(`SPB_REG_CON1, v);
        check(v, 16'h1820);
        check({14'h0, sck_oe_n, sdo_oe_n}, 16'h0003);
        wreg(`SPB_REG_CON1, 16'h0020);
        rreg(`SPB_REG_CON1, v);
        check({14'h0, sck_oe_n, sdo_oe_n}, 16'h0000);
    endtask : test_release
    initial begin
        repeat (6) @(posedge mclk_in);
        rst_in <= 1'b0;
        test_reset();
        test_standard();
        test_fifo();
        test_release();
        conclude();
    end
endmodule : spb_core_bench
`default_nettype wire
